/* File: hdl/wl_pkg.sv */
package wl_pkg;
    // ----------------------------------------------------------------
    // Mode register 1 fields and mode register indices
    // ----------------------------------------------------------------
    localparam int MR1_LEVEL_BIT = 7;
    localparam int MR1_QUIET_BIT = 12;
    localparam int MR1_DYN_WR_LSB = 9;
    localparam int MR1_DYN_WR_W = 3;
    localparam logic [2:0] MR1_INDEX = 3'h1;
    localparam logic [2:0] MR2_INDEX = 3'h2;

    // ----------------------------------------------------------------
    // Timing, in ns, and cycle counts at 100 MHz
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int MODE_DELAY_NS = 30;
    localparam int MODE_CYCLE_NS = 20;
    localparam int ODT_TURN_ON_NS = 40;
    localparam int ODT_ADJUST_NS = 20;
    localparam int ASYNC_ODT_NS = 10;
    localparam int FIRST_EDGE_NS = 400;
    localparam int STROBE_LOW_NS = 20;
    localparam int STROBE_HIGH_NS = 20;
    localparam int FEEDBACK_WAIT_NS = 100;
    localparam int MODE_DELAY_CYC = (MODE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MODE_CYCLE_CYC = (MODE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ODT_TURN_ON_CYC = (ODT_TURN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ODT_ADJUST_CYC = (ODT_ADJUST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ASYNC_ODT_CYC = (ASYNC_ODT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FIRST_EDGE_CYC = (FIRST_EDGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FEEDBACK_WAIT_CYC = (FEEDBACK_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EN_DLL_ON_CYC = MODE_DELAY_CYC + ODT_TURN_ON_CYC + ODT_ADJUST_CYC + 1;
    localparam int EN_DLL_OFF_CYC = MODE_DELAY_CYC + ASYNC_ODT_CYC + 1;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int LANES = 2;
    localparam int DQ_PER_LANE = 8;
    localparam int DELAY_W = 6;
    localparam int CNT_W = 8;
    localparam int RANKS = 2;

    // ----------------------------------------------------------------
    // Software registers (word offsets on the command port)
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_MR1 = 4'h2;
    localparam logic [3:0] REG_DELAY = 4'h3;
    localparam int CTRL_START = 0;
    localparam int CTRL_DLL_OFF = 1;
    localparam int CTRL_LAT_UP = 2;
    localparam int CTRL_USE_ODT = 3;
    localparam int CTRL_RANK = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0008;
    localparam logic [31:0] MR1_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        CMD_DESELECT,
        CMD_MODE_WRITE
    } cmd_e;

    typedef struct packed {
        cmd_e cmd;
        logic [2:0] mr_index;
        logic [RANKS-1:0] rank_sel;
        logic [13:0] addr;
    } dram_cmd_s;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } sw_req_s;
endpackage

/* File: hdl/wl_pin_sync.sv */
`timescale 1ns/100ps
module wl_pin_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;

    // Two stages; nothing but the second stage reads the first
    always_ff @(posedge clock) begin
        if (reset) begin
            meta_q <= '0;
            dout <= '0;
        end else if (clk_en) begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

/* File: hdl/wl_lane_track.sv */
`timescale 1ns/100ps
module wl_lane_track
    import wl_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic clear,
    input wire logic sample,
    input wire logic [DQ_PER_LANE-1:0] dq,
    output logic [DELAY_W-1:0] delay,
    output logic locked,
    output logic fault
);
    logic prev_q;
    logic seen_q;
    logic bit_now;

    // Majority of the lane bits rides over the output skew window
    always_comb begin
        int ones;
        ones = 0;
        for (int i = 0; i < DQ_PER_LANE; i++) begin
            ones = ones + int'(dq[i]);
        end
        bit_now = (ones > DQ_PER_LANE / 2);
    end

    always_ff @(posedge clock) begin
        if (reset || (clk_en && clear)) begin
            prev_q <= 1'b0;
            seen_q <= 1'b0;
            delay <= '0;
            locked <= 1'b0;
            fault <= 1'b0;
        end else if (clk_en && sample && !locked && !fault) begin
            prev_q <= bit_now;
            seen_q <= 1'b1;
            if (seen_q && !prev_q && bit_now) begin
                locked <= 1'b1;
            end else if (delay == '1) begin
                fault <= 1'b1;
            end else begin
                delay <= delay + 1'b1;
            end
        end
    end
endmodule

/* File: hdl/wl_controller.sv */
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module wl_controller
    import wl_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic clk_en,
    input wl_pkg::sw_req_s sw_req,
    output logic [31:0] sw_rdata,
    output wl_pkg::dram_cmd_s dram_cmd,
    output logic dram_odt,
    output logic [LANES-1:0] dqs_t_out,
    output logic [LANES-1:0] dqs_c_out,
    output logic [LANES-1:0] dqs_oe,
    output logic [LANES*DELAY_W-1:0] dqs_delay,
    output logic dq_term_en,
    input wire logic [LANES*DQ_PER_LANE-1:0] dq_in
);
    import wl_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_PREP,
        ST_ENTER,
        ST_ODT_WAIT,
        ST_EN_WAIT,
        ST_PARK,
        ST_HIGH,
        ST_LOW,
        ST_FEEDBACK,
        ST_ODT_OFF,
        ST_EXIT,
        ST_EXIT_WAIT,
        ST_DONE
    } state_e;

    state_e state_q;
    logic [CNT_W-1:0] cnt_q;
    logic [31:0] ctrl_q;
    logic [31:0] mr1_q;
    logic [LANES*DQ_PER_LANE-1:0] dq_sync;
    logic [LANES-1:0] lane_locked;
    logic [LANES-1:0] lane_fault;
    logic sample_pulse;
    logic clear_pulse;
    logic all_done;
    logic [RANKS-1:0] rank_mask;
    logic [CNT_W-1:0] en_delay;
    logic [CNT_W-1:0] odt_delay;

    // ----------------------------------------------------------------
    // Feedback pins
    // ----------------------------------------------------------------
    wl_pin_sync #(.W(LANES*DQ_PER_LANE)) u_dq_sync (
        .clock(clock),
        .reset(reset),
        .clk_en(clk_en),
        .din(dq_in),
        .dout(dq_sync)
    );

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            wl_lane_track u_track (
                .clock(clock),
                .reset(reset),
                .clk_en(clk_en),
                .clear(clear_pulse),
                .sample(sample_pulse),
                .dq(dq_sync[g*DQ_PER_LANE +: DQ_PER_LANE]),
                .delay(dqs_delay[g*DELAY_W +: DELAY_W]),
                .locked(lane_locked[g]),
                .fault(lane_fault[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_q <= CTRL_RESET;
            mr1_q <= MR1_RESET;
        end else if (clk_en) begin
            if (sw_req.wr && sw_req.addr == REG_CTRL) begin
                ctrl_q <= sw_req.wdata;
            end else if (sw_req.wr && sw_req.addr == REG_MR1) begin
                mr1_q <= sw_req.wdata;
            end else if (state_q == ST_PREP) begin
                ctrl_q[CTRL_START] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            sw_rdata <= '0;
        end else if (clk_en) begin
            sw_rdata <= '0;
            if (sw_req.rd) begin
                if (sw_req.addr == REG_CTRL) begin
                    sw_rdata <= ctrl_q;
                end else if (sw_req.addr == REG_STATUS) begin
                    sw_rdata <= {22'h0, lane_fault, lane_locked, 2'h0, 4'(state_q)};
                end else if (sw_req.addr == REG_MR1) begin
                    sw_rdata <= mr1_q;
                end else if (sw_req.addr == REG_DELAY) begin
                    sw_rdata <= {20'h0, dqs_delay};
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    assign rank_mask = RANKS'(1) << ctrl_q[CTRL_RANK];
    assign all_done = &(lane_locked | lane_fault);
    // bound on the enable delay follows the DLL state
    assign en_delay = ctrl_q[CTRL_DLL_OFF] ? CNT_W'(EN_DLL_OFF_CYC) : CNT_W'(EN_DLL_ON_CYC);
    // a latency change pushes ODT out by the turn-on latency
    assign odt_delay = ctrl_q[CTRL_LAT_UP] ? CNT_W'(MODE_DELAY_CYC + ODT_TURN_ON_CYC)
                                           : CNT_W'(MODE_DELAY_CYC);
    assign sample_pulse = (state_q == ST_FEEDBACK) && (cnt_q == '0);
    // A restart from done must drop the old lock and fault state too
    assign clear_pulse = (state_q == ST_IDLE || state_q == ST_DONE) && ctrl_q[CTRL_START];

    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
        end else if (clk_en) begin
            if (cnt_q != '0) begin
                cnt_q <= cnt_q - 1'b1;
            end
            case (state_q)
                ST_IDLE: begin
                    if (ctrl_q[CTRL_START]) begin
                        state_q <= ST_PREP;
                    end
                end
                ST_PREP: begin
                    state_q <= ST_ENTER;
                    cnt_q <= CNT_W'(MODE_CYCLE_CYC);
                end
                ST_ENTER: begin
                    if (cnt_q == '0) begin
                        state_q <= ST_ODT_WAIT;
                        cnt_q <= odt_delay;
                    end
                end
                ST_ODT_WAIT: begin
                    if (cnt_q == '0) begin
                        state_q <= ST_EN_WAIT;
                        cnt_q <= en_delay;
                    end
                end
                ST_EN_WAIT: begin
                    if (cnt_q == '0) begin
                        state_q <= ST_PARK;
                        cnt_q <= CNT_W'(FIRST_EDGE_CYC);
                    end
                end
                ST_PARK: begin
                    if (cnt_q == '0) begin
                        state_q <= ST_HIGH;
                        cnt_q <= CNT_W'(STROBE_HIGH_CYC);
                    end
                end
                ST_HIGH: begin
                    if (cnt_q == '0) begin
                        state_q <= ST_LOW;
                        cnt_q <= CNT_W'(STROBE_LOW_CYC);
                    end
                end
                ST_LOW: begin
                    if (cnt_q == '0) begin
                        state_q <= ST_FEEDBACK;
                        cnt_q <= CNT_W'(FEEDBACK_WAIT_CYC);
                    end
                end
                ST_FEEDBACK: begin
                    if (cnt_q == '0) begin
                        state_q <= ST_FEEDBACK;
                    end
                end
                ST_ODT_OFF: begin
                    if (cnt_q == '0) begin
                        state_q <= ST_EXIT;
                    end
                end
                ST_EXIT: begin
                    state_q <= ST_EXIT_WAIT;
                    cnt_q <= CNT_W'(MODE_DELAY_CYC);
                end
                ST_EXIT_WAIT: begin
                    if (cnt_q == '0) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (ctrl_q[CTRL_START]) begin
                        state_q <= ST_PREP;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
            // Decision after a feedback sample overrides the hold above
            if (sample_pulse) begin
                // new pulse after each step, until lanes settle
                if (all_done) begin
                    state_q <= ST_ODT_OFF;
                    cnt_q <= CNT_W'(ODT_TURN_ON_CYC);
                end else begin
                    state_q <= ST_PARK;
                    cnt_q <= CNT_W'(STROBE_LOW_CYC);
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Pins
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            dram_cmd <= '{cmd: CMD_DESELECT, mr_index: 3'h0, rank_sel: '0, addr: 14'h0};
        end else if (clk_en) begin
            dram_cmd <= '{cmd: CMD_DESELECT, mr_index: 3'h0, rank_sel: '0, addr: 14'h0};
            if (state_q == ST_PREP) begin
                // dynamic termination off, all ranks level, outputs quiet
                dram_cmd.cmd <= CMD_MODE_WRITE;
                dram_cmd.mr_index <= MR1_INDEX;
                dram_cmd.rank_sel <= '1;
                dram_cmd.addr <= mr1_q[13:0];
                dram_cmd.addr[MR1_LEVEL_BIT] <= 1'b1;
                dram_cmd.addr[MR1_QUIET_BIT] <= 1'b1;
                dram_cmd.addr[MR1_DYN_WR_LSB +: MR1_DYN_WR_W] <= '0;
            end else if (state_q == ST_ENTER && cnt_q == CNT_W'(1)) begin
                // Target rank outputs back on, leveling still set
                dram_cmd.cmd <= CMD_MODE_WRITE;
                dram_cmd.mr_index <= MR1_INDEX;
                dram_cmd.rank_sel <= rank_mask;
                dram_cmd.addr <= mr1_q[13:0];
                dram_cmd.addr[MR1_LEVEL_BIT] <= 1'b1;
                dram_cmd.addr[MR1_QUIET_BIT] <= 1'b0;
                dram_cmd.addr[MR1_DYN_WR_LSB +: MR1_DYN_WR_W] <= '0;
            end else if (state_q == ST_EXIT) begin
                // exit write restores the software value with the leveling bit cleared
                dram_cmd.cmd <= CMD_MODE_WRITE;
                dram_cmd.mr_index <= MR1_INDEX;
                dram_cmd.rank_sel <= '1;
                dram_cmd.addr <= mr1_q[13:0];
                dram_cmd.addr[MR1_LEVEL_BIT] <= 1'b0;
            end
        end
    end

    // ODT only from the end of its wait until ST_ODT_OFF
    always_ff @(posedge clock) begin
        if (reset) begin
            dram_odt <= 1'b0;
        end else if (clk_en) begin
            dram_odt <= ctrl_q[CTRL_USE_ODT] && (state_q == ST_EN_WAIT || state_q == ST_PARK
                        || state_q == ST_HIGH || state_q == ST_LOW || state_q == ST_FEEDBACK);
        end
    end

    // strobe driven from park until after last pulse
    generate
        for (g = 0; g < LANES; g++) begin : g_strobe
            always_ff @(posedge clock) begin
                if (reset) begin
                    dqs_t_out[g] <= 1'b0;
                    dqs_c_out[g] <= 1'b1;
                    dqs_oe[g] <= 1'b0;
                end else if (clk_en) begin
                    dqs_t_out[g] <= (state_q == ST_HIGH) && !lane_locked[g];
                    dqs_c_out[g] <= !((state_q == ST_HIGH) && !lane_locked[g]);
                    dqs_oe[g] <= (state_q == ST_PARK || state_q == ST_HIGH
                                  || state_q == ST_LOW || state_q == ST_FEEDBACK);
                end
            end
        end
    endgenerate

    // controller terminates DQ while leveling; need no strobe
    always_ff @(posedge clock) begin
        if (reset) begin
            dq_term_en <= 1'b0;
        end else if (clk_en) begin
            dq_term_en <= (state_q != ST_IDLE) && (state_q != ST_DONE);
        end
    end
endmodule

/* File: bench/wl_checker.sv */
`timescale 1ns/100ps
module wl_checker
    import wl_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic clk_en,
    input wl_pkg::sw_req_s sw_req,
    input wire logic [31:0] sw_rdata,
    input wl_pkg::dram_cmd_s dram_cmd,
    input wire logic dram_odt,
    input wire logic [LANES-1:0] dqs_t_out,
    input wire logic [LANES-1:0] dqs_c_out,
    input wire logic [LANES-1:0] dqs_oe,
    input wire logic [LANES*DELAY_W-1:0] dqs_delay,
    input wire logic dq_term_en,
    input wire logic [LANES*DQ_PER_LANE-1:0] dq_in
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic [7:0] since_mw_q;
    logic mw, mr1w;
    assign mw = dram_cmd.cmd == CMD_MODE_WRITE;
    assign mr1w = mw && dram_cmd.mr_index == MR1_INDEX;
    // Saturates, so long idle stretches never wrap into a false short gap
    always_ff @(posedge clock) begin
        if (reset || mw) begin
            since_mw_q <= 8'h00;
        end else if (since_mw_q != 8'hff) begin
            since_mw_q <= since_mw_q + 8'h01;
        end
    end
    // ----------------
    // Properties
    // ----------------
    chk_cmd_legal: assert property (mw |-> dram_cmd.mr_index == MR1_INDEX ##1 !mw)
        else $error("mode write not a single MR1 pulse");
    chk_one_target: assert property (mr1w && dram_cmd.addr[MR1_LEVEL_BIT] && !dram_cmd.addr[MR1_QUIET_BIT] |->
        $onehot(dram_cmd.rank_sel)) else $error("more than one rank unquiet");
    chk_dyn_wr_off: assert property (mr1w && dram_cmd.addr[MR1_LEVEL_BIT] |->
        dram_cmd.addr[MR1_DYN_WR_LSB +: MR1_DYN_WR_W] == '0) else $error("dynamic termination left on");
    chk_odt_wait: assert property ($rose(dram_odt) |-> since_mw_q >= MODE_DELAY_CYC)
        else $error("termination raised too early");
    chk_strobe_park: assert property ($rose(dqs_oe[0]) |->
        !dqs_t_out[0] && dqs_c_out[0] && since_mw_q >= EN_DLL_OFF_CYC) else $error("bad strobe park");
    chk_strobe_diff: assert property (((dqs_t_out ^ dqs_c_out) | ~dqs_oe) == '1)
        else $error("strobe pair not complementary");
    chk_first_edge: assert property ($rose(dqs_t_out[0]) |-> dqs_oe[0] && since_mw_q >= FIRST_EDGE_CYC)
        else $error("first strobe edge too early");
    chk_high_width: assert property ($rose(dqs_t_out[1]) |-> dqs_t_out[1] [*2])
        else $error("strobe high too short");
    chk_low_width: assert property ($fell(dqs_t_out[0]) |-> !dqs_t_out[0] [*2])
        else $error("strobe low too short");
    chk_exit_quiet: assert property (mr1w && !dram_cmd.addr[MR1_LEVEL_BIT] |->
        !dram_odt && !$past(dram_odt) && dqs_oe == '0) else $error("exit write with strobe or odt on");
    chk_exit_gap: assert property (mr1w && !dram_cmd.addr[MR1_LEVEL_BIT] |=> !mw [*2])
        else $error("mode write too soon after exit");
    chk_term_dq: assert property (dqs_oe != '0 |-> dq_term_en)
        else $error("feedback lines unterminated");
    cover property ($rose(dram_odt));
    cover property ($rose(dqs_t_out[1]));
    cover property (mr1w && !dram_cmd.addr[MR1_LEVEL_BIT]);
endmodule

bind wl_controller wl_checker u_chk (.clock(clock), .reset(reset), .clk_en(clk_en), .sw_req(sw_req),
    .sw_rdata(sw_rdata), .dram_cmd(dram_cmd), .dram_odt(dram_odt), .dqs_t_out(dqs_t_out),
    .dqs_c_out(dqs_c_out), .dqs_oe(dqs_oe), .dqs_delay(dqs_delay), .dq_term_en(dq_term_en), .dq_in(dq_in));

/* File: bench/wl_dram_model.sv */
`timescale 1ns/100ps
module wl_dram_model
    import wl_pkg::*;
#(
    parameter int RANK = 0
) (
    input wire logic clock,
    input wire logic reset,
    input wl_pkg::dram_cmd_s cmd,
    input wire logic odt,
    input wire logic [LANES-1:0] dqs_t,
    input wire logic [LANES-1:0] dqs_oe,
    input wire logic [LANES*DELAY_W-1:0] dqs_delay,
    input wire logic [13:0] skew,
    output logic [LANES*DQ_PER_LANE-1:0] dq,
    output logic [1:0] term_sel,
    output logic [13:0] mr1,
    output logic [7:0] viol
);
    logic [LANES-1:0] fb_q, seen_q, prev_q, rise;
    logic [15:0] alt_q;
    logic sel, lvl, on, bad_entry, bad_cmd;
    assign sel = cmd.cmd == CMD_MODE_WRITE && cmd.mr_index == MR1_INDEX && cmd.rank_sel[RANK];
    assign lvl = mr1[MR1_LEVEL_BIT];
    assign on = lvl && !mr1[MR1_QUIET_BIT];
    assign rise = dqs_t & dqs_oe & ~prev_q;
    assign bad_entry = sel && !lvl && cmd.addr[MR1_LEVEL_BIT] && cmd.addr[11:9] != 3'h0;
    // Only the quiet bit may move, unless the same write ends leveling
    assign bad_cmd = lvl && cmd.cmd != CMD_DESELECT && cmd.rank_sel[RANK]
        && !(sel && (!cmd.addr[MR1_LEVEL_BIT] || ((cmd.addr ^ mr1) & 14'h2f7f) == 14'h0000));
    assign term_sel = lvl ? (odt ? 2'h1 : 2'h2) : 2'h0;
    // Undriven pins toggle every cycle so a stale level never looks valid
    assign dq[7:0] = (on && seen_q[0]) ? {8{fb_q[0]}} : alt_q[7:0];
    assign dq[15:8] = (on && seen_q[1]) ? {8{fb_q[1]}} : alt_q[15:8];
    always_ff @(posedge clock) begin
        alt_q <= reset ? 16'hff00 : ~alt_q;
        prev_q <= dqs_t & dqs_oe;
        if (reset || !lvl) begin
            seen_q <= '0;
        end else begin
            seen_q <= seen_q | rise;
        end
    end
    // Delay at or past the lane skew means the strobe met the clock high
    always_ff @(posedge clock) begin
        for (int l = 0; l < LANES; l++) begin
            if (reset) begin
                fb_q[l] <= 1'b0;
            end else if (rise[l]) begin
                fb_q[l] <= {1'b0, dqs_delay[l*DELAY_W +: DELAY_W]} >= skew[l*7 +: 7];
            end
        end
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            mr1 <= '0;
            viol <= '0;
        end else begin
            if (sel) begin
                mr1 <= cmd.addr;
            end
            if (bad_entry || bad_cmd) begin
                viol <= viol + 8'h01;
            end
        end
    end
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/100ps
module testbench;
    import wl_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    sw_req_s sw_req = '0;
    logic [31:0] sw_rdata;
    dram_cmd_s dram_cmd;
    logic dram_odt, dq_term_en;
    logic [LANES-1:0] dqs_t_out, dqs_c_out, dqs_oe;
    logic [LANES*DELAY_W-1:0] dqs_delay;
    logic [LANES*DQ_PER_LANE-1:0] dq_in;
    logic [13:0] skew = {7'h09, 7'h05};
    logic [13:0] mr1;
    logic [1:0] term_sel;
    logic [7:0] viol;
    logic [31:0] rd_q;
    logic [15:0] snap;
    int n_fail = 0;
    int total_checks = 0;

    always #5 clock = ~clock;

    wl_controller uut (.clock(clock), .reset(reset), .clk_en(clk_en), .sw_req(sw_req), .sw_rdata(sw_rdata),
        .dram_cmd(dram_cmd), .dram_odt(dram_odt), .dqs_t_out(dqs_t_out), .dqs_c_out(dqs_c_out),
        .dqs_oe(dqs_oe), .dqs_delay(dqs_delay), .dq_term_en(dq_term_en), .dq_in(dq_in));
    wl_dram_model #(.RANK(0)) dram (.clock(clock), .reset(reset), .cmd(dram_cmd), .odt(dram_odt),
        .dqs_t(dqs_t_out), .dqs_oe(dqs_oe), .dqs_delay(dqs_delay), .skew(skew), .dq(dq_in),
        .term_sel(term_sel), .mr1(mr1), .viol(viol));

    // ----------------
    // Tasks
    // ----------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic bus(input logic [3:0] a, input logic [31:0] d, input logic w);
        @(posedge clock);
        sw_req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clock);
        sw_req <= '0;
        #1;
        rd_q = sw_rdata;
    endtask

    task automatic reset_dut;
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
    endtask

    task automatic check_idle;
        @(posedge clock);
        #1;
        check("command", dram_cmd.cmd, CMD_DESELECT);
        check("strobe and odt", {term_sel, dqs_oe, dqs_c_out, dqs_t_out, dram_odt}, 9'h018);
    endtask

    task automatic run(input logic [31:0] ctrl, input logic [3:0] st);
        int i;
        logic odt_on;
        odt_on = ctrl[CTRL_USE_ODT];
        bus(REG_CTRL, ctrl, 1'b1);
        repeat (60) @(posedge clock);
        clk_en <= 1'b0;
        @(posedge clock);
        #1;
        snap = {dqs_delay, dqs_oe, dqs_t_out};
        check("termination", {term_sel, dram_odt, dq_term_en}, {odt_on ? 2'h1 : 2'h2, odt_on, 1'b1});
        check("level target", {mr1[MR1_QUIET_BIT], mr1[MR1_LEVEL_BIT]}, 2'h1);
        repeat (20) @(posedge clock);
        check("frozen pins", {dqs_delay, dqs_oe, dqs_t_out}, snap);
        clk_en <= 1'b1;
        for (i = 0; i < 3000; i++) begin
            bus(REG_STATUS, 32'h0, 1'b0);
            if ((rd_q[7:6] | rd_q[9:8]) == 2'h3 && mr1[MR1_LEVEL_BIT] === 1'b0) begin
                break;
            end
        end
        if (i == 3000) begin
            n_fail++;
            $display("Error leveling end expected done seen timeout");
            report_and_stop;
        end else begin
            check("lane status", rd_q[9:6], st);
            check("command faults", viol, 8'h00);
            check_idle;
            bus(REG_CTRL, 32'h0, 1'b0);
            check("start cleared", rd_q, ctrl & 32'hffff_fffe);
        end
    endtask

    // ----------------
    // Sequence
    // ----------------
    initial begin
        reset_dut;
        check_idle;
        bus(REG_CTRL, 32'h0, 1'b0);
        check("control reset", rd_q, CTRL_RESET);
        bus(REG_MR1, 32'h0, 1'b0);
        check("mode base reset", rd_q, MR1_RESET);
        bus(REG_DELAY, 32'h0, 1'b0);
        check("delay reset", rd_q, 32'h0);
        bus(4'hf, 32'hffff_ffff, 1'b1);
        bus(4'hf, 32'h0, 1'b0);
        check("unmapped", rd_q, 32'h0);
        bus(REG_MR1, 32'h0000_0e01, 1'b1);
        bus(REG_MR1, 32'h0, 1'b0);
        check("mode base", rd_q, 32'h0000_0e01);
        $display("Test registers done");
        run(32'h0000_0009, 4'h3);
        bus(REG_DELAY, 32'h0, 1'b0);
        check("lane delays", rd_q[11:0], {6'h09, 6'h05});
        check("dq termination off", dq_term_en, 1'b0);
        check("exit keeps base", mr1[0], 1'b1);
        check("target not quiet", mr1[MR1_QUIET_BIT], 1'b0);
        $display("Test leveling done");
        reset_dut;
        skew <= {7'h40, 7'h03};
        run(32'h0000_000f, 4'h9);
        check("lane0 delay", dqs_delay[5:0], 6'h03);
        $display("Test fault lane done");
        report_and_stop;
    end
endmodule
